// *** bsp_params.svh ***
// constants of the two-word burst sram port: widths, timing counts
// assumes a 125 MHz sys_clk on both ends of the link
`ifndef BSP_PARAMS_SVH
`define BSP_PARAMS_SVH
// ****************************************
// bus geometry
// ****************************************
`define BSP_DQ_W 36
`define BSP_BYTE_W 9
`define BSP_BW_W 4
`define BSP_ADDR_W 20
`define BSP_WORDS_WIDE 1048576
`define BSP_WORDS_NARROW 2097152
// ****************************************
// timing
// ****************************************
`define BSP_SYS_PERIOD_NS 8
`define BSP_KHALF 8
`define BSP_SETTLE_US 20
`define BSP_SETTLE_CYC ((`BSP_SETTLE_US * 1000 + `BSP_SYS_PERIOD_NS - 1) / `BSP_SYS_PERIOD_NS)
`define BSP_LOCK_EDGES 16
`endif

// *** bsp_pkg.sv ***
// types used by the host end of the burst sram port
// assumes nothing beyond a SystemVerilog compiler
package bsp_pkg;
   // ****************************************
   // host bring-up states
   // ****************************************
   typedef enum logic [2:0] {
      BSP_PWR    = 3'h1,
      BSP_SETTLE = 3'h2,
      BSP_RUN    = 3'h4
   } bsp_init_t;
endpackage : bsp_pkg

// *** bsp_if.sv ***
// pins between the host controller and the burst sram
// assumes the bench joins one bsp_host and one bsp_device to it
`timescale 1ns/1ps
`include "bsp_params.svh"
interface bsp_if #(
   parameter int ADDR_W = `BSP_ADDR_W
);
   logic                   k;
   logic                   kN;
   logic                   c;
   logic                   cN;
   logic                   load_strobe_n;
   logic                   rw;
   logic                   pll_bypass_n;
   logic [ADDR_W-1:0]      addr_in;
   logic [`BSP_BW_W-1:0]   byte_enable_n;
   logic [`BSP_DQ_W-1:0]   dqHost;
   logic                   dqHostOe;
   logic [`BSP_DQ_W-1:0]   dqDev;
   logic [`BSP_DQ_W-1:0]   dqDevOe;
   logic [`BSP_DQ_W-1:0]   dq;
   logic                   echo_strobe_pos;
   logic                   echo_strobe_neg;
   // ****************************************
   // shared data wire, undriven lines read low
   // ****************************************
   assign dq = (dqDev & dqDevOe) | (dqHost & ~dqDevOe & {`BSP_DQ_W{dqHostOe}});
   modport dev (
      input  k, kN, c, cN, load_strobe_n, rw, pll_bypass_n, addr_in, byte_enable_n, dq,
      output dqDev, dqDevOe, echo_strobe_pos, echo_strobe_neg
   );
   modport host (
      output k, kN, c, cN, load_strobe_n, rw, pll_bypass_n, addr_in, byte_enable_n,
      output dqHost, dqHostOe,
      input  dq, echo_strobe_pos, echo_strobe_neg
   );
endinterface : bsp_if

// *** bsp_host.sv ***
// host end: makes the clock pairs, loads commands, captures read bursts
// assumes a user that holds a request until reqAck, and the sram on bus
`timescale 1ns/1ps
`include "bsp_params.svh"
module bsp_host #(
   parameter int ADDR_W     = `BSP_ADDR_W,
   parameter int USED_W     = `BSP_DQ_W,
   parameter int BW         = USED_W / `BSP_BYTE_W,
   parameter int KHALF      = `BSP_KHALF,
   parameter int SETTLE_CYC = `BSP_SETTLE_CYC
) (
   input  wire logic              sys_clk,
   input  wire logic              nrst,
   bsp_if.host                    bus,
   input  wire logic              coreSupplyOk,
   input  wire logic              singleClock,
   input  wire logic              bypassPll,
   input  wire logic              reqValid,
   input  wire logic              reqWrite,
   input  wire logic [ADDR_W-1:0] reqAddr,
   input  wire logic [USED_W-1:0] reqData0,
   input  wire logic [USED_W-1:0] reqData1,
   input  wire logic [BW-1:0]     reqBe0,
   input  wire logic [BW-1:0]     reqBe1,
   output logic                   reqAck,
   output logic                   rdValid,
   output logic [USED_W-1:0]      rdData0,
   output logic [USED_W-1:0]      rdData1,
   output logic                   linkReady
);
   localparam logic [7:0]  PH_LAST   = 8'(2 * KHALF - 1);
   localparam logic [7:0]  PH_H      = 8'(KHALF);
   localparam logic [7:0]  PH_LAUNCH = 8'(KHALF + KHALF / 2);
   localparam logic [7:0]  PH_W1     = 8'(KHALF / 2);
   localparam logic [15:0] SET_LAST  = 16'(SETTLE_CYC - 1);
   localparam int          SW        = 3 + USED_W;
   // ****************************************
   // input synchronisers
   // ****************************************
   logic [SW-1:0]     syncA;
   logic [SW-1:0]     syncB;
   logic              pwrS;
   logic              ePS;
   logic              eNS;
   logic [USED_W-1:0] dqS;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         syncA <= '0;
         syncB <= '0;
      end else begin
         syncA <= {coreSupplyOk, bus.echo_strobe_pos, bus.echo_strobe_neg, bus.dq[USED_W-1:0]};
         syncB <= syncA;
      end
   end
   assign {pwrS, ePS, eNS, dqS} = syncB;
   // ****************************************
   // state
   // ****************************************
   bsp_pkg::bsp_init_t st, next_st;
   logic [7:0]  ph, next_ph, advPh;
   logic [15:0] cnt, next_cnt;
   logic k, next_k, kN, next_kN, c, next_c, cN, next_cN, byp, next_byp;
   logic ldN, next_ldN, rw, next_rw, oe, next_oe, send1, next_send1;
   logic wrPend, next_wrPend, lastRd, next_lastRd, got0, next_got0;
   logic eD, next_eD, pD, next_pD, next_reqAck, next_rdValid, next_linkReady;
   logic [ADDR_W-1:0]      addr, next_addr;
   logic [`BSP_DQ_W-1:0]   dqH, next_dqH;
   logic [`BSP_BW_W-1:0]   beN, next_beN;
   logic [USED_W-1:0]      wrD0, next_wrD0, wrD1, next_wrD1, d1, next_d1;
   logic [USED_W-1:0]      cap0, next_cap0, next_rdData0, next_rdData1;
   logic [BW-1:0]          wrBe0, next_wrBe0, wrBe1, next_wrBe1, be1, next_be1;
   logic [2:0]             rdQ, next_rdQ;
   always_comb begin
      next_st = st;
      next_ph = ph;
      next_cnt = cnt;
      next_k = k;
      next_kN = kN;
      next_ldN = ldN;
      next_rw = rw;
      next_addr = addr;
      next_dqH = dqH;
      next_beN = beN;
      next_oe = oe;
      next_send1 = send1;
      next_wrPend = wrPend;
      next_wrD0 = wrD0;
      next_wrD1 = wrD1;
      next_wrBe0 = wrBe0;
      next_wrBe1 = wrBe1;
      next_d1 = d1;
      next_be1 = be1;
      next_lastRd = lastRd;
      next_rdQ = rdQ;
      next_got0 = got0;
      next_cap0 = cap0;
      next_rdData0 = rdData0;
      next_rdData1 = rdData1;
      next_linkReady = linkReady;
      next_reqAck = 1'b0;
      next_rdValid = 1'b0;
      next_eD = eNS;
      next_pD = ePS;
      next_byp = ~(bypassPll & ~singleClock);
      advPh = (ph == PH_LAST) ? 8'h00 : ph + 8'h01;
      case (st)
         bsp_pkg::BSP_PWR: begin
            // clocks held stopped until the core supply is good
            next_k = 1'b0;
            next_kN = 1'b1;
            next_ph = PH_LAST;
            next_cnt = 16'h0000;
            if (pwrS) begin
               next_st = bsp_pkg::BSP_SETTLE;
            end
         end
         bsp_pkg::BSP_SETTLE: begin
            next_ph = advPh;
            if (cnt == SET_LAST) begin
               next_st = bsp_pkg::BSP_RUN;
               next_linkReady = 1'b1;
            end else begin
               next_cnt = cnt + 16'h0001;
            end
         end
         bsp_pkg::BSP_RUN: begin
            next_ph = advPh;
         end
         default: begin
            next_st = bsp_pkg::BSP_PWR;
         end
      endcase
      if (st != bsp_pkg::BSP_PWR) begin
         next_k = (next_ph < PH_H);
         next_kN = ~next_k;
      end
      // tied-high pair must never toggle while running
      next_c = singleClock ? 1'b1 : next_k;
      next_cN = singleClock ? 1'b1 : next_kN;
      if (st != bsp_pkg::BSP_PWR && next_ph == 8'h00) begin
         next_rdQ = {rdQ[1:0], ~ldN & rw};
      end
      if (st == bsp_pkg::BSP_RUN && next_ph == PH_LAUNCH) begin
         next_ldN = 1'b1;
         next_oe = 1'b0;
         next_wrPend = 1'b0;
         next_lastRd = 1'b0;
         if (wrPend) begin
            next_dqH[USED_W-1:0] = wrD0;
            next_beN = '1;
            next_beN[BW-1:0] = ~wrBe0;
            next_oe = 1'b1;
            next_d1 = wrD1;
            next_be1 = wrBe1;
            next_send1 = 1'b1;
         end
         // a write straight after a read would collide on the data wire
         if (reqValid && !(reqWrite && lastRd)) begin
            next_ldN = 1'b0;
            next_rw = ~reqWrite;
            next_addr = reqAddr;
            next_reqAck = 1'b1;
            next_lastRd = ~reqWrite;
            if (reqWrite) begin
               next_wrPend = 1'b1;
               next_wrD0 = reqData0;
               next_wrD1 = reqData1;
               next_wrBe0 = reqBe0;
               next_wrBe1 = reqBe1;
            end
         end
      end
      if (st == bsp_pkg::BSP_RUN && next_ph == PH_W1 && send1) begin
         next_dqH[USED_W-1:0] = d1;
         next_beN = '1;
         next_beN[BW-1:0] = ~be1;
         next_send1 = 1'b0;
      end
      if (eNS && !eD && rdQ[1]) begin
         next_cap0 = dqS;
         next_got0 = 1'b1;
      end
      if (ePS && !pD && got0 && rdQ[2]) begin
         next_rdData0 = cap0;
         next_rdData1 = dqS;
         next_rdValid = 1'b1;
         next_got0 = 1'b0;
      end
   end
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         st <= bsp_pkg::BSP_PWR;
         ph <= 8'h00;
         cnt <= 16'h0000;
         k <= 1'h0;
         kN <= 1'h1;
         c <= 1'h1;
         cN <= 1'h1;
         byp <= 1'h1;
         ldN <= 1'h1;
         rw <= 1'h0;
         addr <= '0;
         dqH <= '0;
         beN <= '1;
         oe <= 1'h0;
         send1 <= 1'h0;
         wrPend <= 1'h0;
         wrD0 <= '0;
         wrD1 <= '0;
         wrBe0 <= '0;
         wrBe1 <= '0;
         d1 <= '0;
         be1 <= '0;
         lastRd <= 1'h0;
         rdQ <= 3'h0;
         got0 <= 1'h0;
         cap0 <= '0;
         eD <= 1'h0;
         pD <= 1'h0;
         reqAck <= 1'h0;
         rdValid <= 1'h0;
         rdData0 <= '0;
         rdData1 <= '0;
         linkReady <= 1'h0;
      end else begin
         st <= next_st;
         ph <= next_ph;
         cnt <= next_cnt;
         k <= next_k;
         kN <= next_kN;
         c <= next_c;
         cN <= next_cN;
         byp <= next_byp;
         ldN <= next_ldN;
         rw <= next_rw;
         addr <= next_addr;
         dqH <= next_dqH;
         beN <= next_beN;
         oe <= next_oe;
         send1 <= next_send1;
         wrPend <= next_wrPend;
         wrD0 <= next_wrD0;
         wrD1 <= next_wrD1;
         wrBe0 <= next_wrBe0;
         wrBe1 <= next_wrBe1;
         d1 <= next_d1;
         be1 <= next_be1;
         lastRd <= next_lastRd;
         rdQ <= next_rdQ;
         got0 <= next_got0;
         cap0 <= next_cap0;
         eD <= next_eD;
         pD <= next_pD;
         reqAck <= next_reqAck;
         rdValid <= next_rdValid;
         rdData0 <= next_rdData0;
         rdData1 <= next_rdData1;
         linkReady <= next_linkReady;
      end
   end
   assign bus.k = k;
   assign bus.kN = kN;
   assign bus.c = c;
   assign bus.cN = cN;
   assign bus.pll_bypass_n = byp;
   assign bus.load_strobe_n = ldN;
   assign bus.rw = rw;
   assign bus.addr_in = addr;
   assign bus.byte_enable_n = beN;
   assign bus.dqHost = dqH;
   assign bus.dqHostOe = oe;
endmodule : bsp_host

// *** bsp_device.sv ***
// sram end: two-word burst memory behind the synchronous port
// assumes a host that makes the clock pairs and keeps the bus timing
`timescale 1ns/1ps
`include "bsp_params.svh"
module bsp_device #(
   parameter int USED_W     = `BSP_DQ_W,
   parameter int ADDR_W     = `BSP_ADDR_W,
   parameter int LOCK_EDGES = `BSP_LOCK_EDGES
) (
   input  wire logic sys_clk,
   input  wire logic nrst,
   bsp_if.dev        bus,
   output logic      pllLocked
);
   localparam int BW = USED_W / `BSP_BYTE_W;
   localparam int SW = 7 + ADDR_W + BW + USED_W;
   localparam int DEPTH = 2 ** ADDR_W;
   localparam logic [`BSP_DQ_W-1:0] USED_MASK =
      {`BSP_DQ_W{1'b1}} >> (`BSP_DQ_W - USED_W);
   localparam logic [7:0] LOCK_LAST = 8'(LOCK_EDGES - 1);
   // ****************************************
   // input synchronisers
   // ****************************************
   logic [SW-1:0]     syncA;
   logic [SW-1:0]     syncB;
   logic              kS;
   logic              kNS;
   logic              cS;
   logic              cNS;
   logic              ldNS;
   logic              rwS;
   logic              bypNS;
   logic [ADDR_W-1:0] addrS;
   logic [BW-1:0]     bwNS;
   logic [USED_W-1:0] dqS;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         syncA <= '0;
         syncB <= '0;
      end else begin
         syncA <= {bus.k, bus.kN, bus.c, bus.cN, bus.load_strobe_n, bus.rw,
                   bus.pll_bypass_n, bus.addr_in, bus.byte_enable_n[BW-1:0],
                   bus.dq[USED_W-1:0]};
         syncB <= syncA;
      end
   end
   assign {kS, kNS, cS, cNS, ldNS, rwS, bypNS, addrS, bwNS, dqS} = syncB;
   // ****************************************
   // clock edges and output reference
   // ****************************************
   logic useK;
   logic refP;
   logic refN;
   logic kD;
   logic kND;
   logic pD;
   logic nD;
   logic kRise;
   logic kNRise;
   logic pRise;
   logic nRise;
   // both output clocks high means the input pair times the outputs
   assign useK = cS & cNS;
   assign refP = useK ? kS : cS;
   assign refN = useK ? kNS : cNS;
   assign kRise = kS & ~kD;
   assign kNRise = kNS & ~kND;
   assign pRise = refP & ~pD;
   assign nRise = refN & ~nD;
   // ****************************************
   // storage
   // ****************************************
   logic [USED_W-1:0] mem [0:DEPTH-1];
   logic              memWe;
   logic [ADDR_W-1:0] memAddr;
   logic [USED_W-1:0] memData;
   logic [BW-1:0]     memMask;
   // no reset on the array: contents are undefined after power-up anyway
   always_ff @(posedge sys_clk) begin
      if (memWe) begin
         for (int b = 0; b < BW; b++) begin
            if (memMask[b]) begin
               mem[memAddr][b*`BSP_BYTE_W +: `BSP_BYTE_W] <=
                  memData[b*`BSP_BYTE_W +: `BSP_BYTE_W];
            end
         end
      end
   end
   // ****************************************
   // burst control
   // ****************************************
   logic                 cmdLd, next_cmdLd;
   logic                 cmdRd, next_cmdRd;
   logic [ADDR_W-1:0]    cmdAddr, next_cmdAddr;
   logic                 wr2, next_wr2;
   logic [ADDR_W-1:0]    wrAddr, next_wrAddr;
   logic                 rdArm, next_rdArm;
   logic [ADDR_W-1:0]    rdAddr, next_rdAddr;
   logic                 rd2, next_rd2;
   logic [ADDR_W-1:0]    rd2Addr, next_rd2Addr;
   logic [`BSP_DQ_W-1:0] dqOut, next_dqOut;
   logic [`BSP_DQ_W-1:0] dqOe, next_dqOe;
   logic                 echoP, next_echoP;
   logic                 echoN, next_echoN;
   logic [7:0]           lockCnt, next_lockCnt;
   logic                 next_pllLocked;
   logic                 bypD, next_bypD;
   always_comb begin
      next_cmdLd = cmdLd;
      next_cmdRd = cmdRd;
      next_cmdAddr = cmdAddr;
      next_wr2 = wr2;
      next_wrAddr = wrAddr;
      next_rdArm = rdArm;
      next_rdAddr = rdAddr;
      next_rd2 = rd2;
      next_rd2Addr = rd2Addr;
      next_dqOut = dqOut;
      next_dqOe = dqOe;
      next_lockCnt = lockCnt;
      next_pllLocked = pllLocked;
      next_bypD = bypNS;
      memWe = 1'b0;
      memAddr = cmdAddr;
      memData = dqS;
      memMask = ~bwNS;
      if (kRise) begin
         // the burst loaded one K cycle ago moves on at this edge
         if (cmdLd && !cmdRd) begin
            memWe = 1'b1;
            next_wr2 = 1'b1;
            next_wrAddr = {cmdAddr[ADDR_W-1:1], ~cmdAddr[0]};
         end
         if (cmdLd && cmdRd) begin
            next_rdArm = 1'b1;
            next_rdAddr = cmdAddr;
         end
         next_cmdLd = !ldNS && pllLocked;
         next_cmdRd = rwS;
         if (!ldNS) begin
            next_cmdAddr = addrS;
         end
      end
      if (kNRise && wr2) begin
         memWe = 1'b1;
         memAddr = wrAddr;
         next_wr2 = 1'b0;
      end
      if (nRise) begin
         if (rdArm) begin
            next_dqOut = '0;
            next_dqOut[USED_W-1:0] = mem[rdAddr];
            next_dqOe = USED_MASK;
            next_rd2 = 1'b1;
            next_rd2Addr = {rdAddr[ADDR_W-1:1], ~rdAddr[0]};
            next_rdArm = 1'b0;
         end else begin
            next_dqOe = '0;
         end
      end
      if (pRise && rd2) begin
         next_dqOut = '0;
         next_dqOut[USED_W-1:0] = mem[rd2Addr];
         next_rd2 = 1'b0;
      end
      // echo follows the output reference whether or not data is driven
      next_echoP = refP;
      next_echoN = refN;
      // a change of the bypass level drops lock; only the PLL path needs a fresh settling period
      if (bypNS != bypD) begin
         next_lockCnt = 8'h00;
         next_pllLocked = 1'b0;
      end else if (!bypNS) begin
         next_pllLocked = 1'b1;
      end else if (kRise && !pllLocked) begin
         if (lockCnt == LOCK_LAST) begin
            next_pllLocked = 1'b1;
         end else begin
            next_lockCnt = lockCnt + 8'h01;
         end
      end
   end
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         kD <= 1'b0;
         kND <= 1'b0;
         pD <= 1'b0;
         nD <= 1'b0;
         cmdLd <= 1'b0;
         cmdRd <= 1'b0;
         cmdAddr <= '0;
         wr2 <= 1'b0;
         wrAddr <= '0;
         rdArm <= 1'b0;
         rdAddr <= '0;
         rd2 <= 1'b0;
         rd2Addr <= '0;
         dqOut <= '0;
         dqOe <= '0;
         echoP <= 1'b0;
         echoN <= 1'b0;
         lockCnt <= 8'h00;
         pllLocked <= 1'b0;
         bypD <= 1'b0;
      end else begin
         kD <= kS;
         kND <= kNS;
         pD <= refP;
         nD <= refN;
         cmdLd <= next_cmdLd;
         cmdRd <= next_cmdRd;
         cmdAddr <= next_cmdAddr;
         wr2 <= next_wr2;
         wrAddr <= next_wrAddr;
         rdArm <= next_rdArm;
         rdAddr <= next_rdAddr;
         rd2 <= next_rd2;
         rd2Addr <= next_rd2Addr;
         dqOut <= next_dqOut;
         dqOe <= next_dqOe;
         echoP <= next_echoP;
         echoN <= next_echoN;
         lockCnt <= next_lockCnt;
         pllLocked <= next_pllLocked;
         bypD <= next_bypD;
      end
   end
   assign bus.dqDev = dqOut;
   assign bus.dqDevOe = dqOe;
   assign bus.echo_strobe_pos = echoP;
   assign bus.echo_strobe_neg = echoN;
endmodule : bsp_device

// *** bsp_assertions.sv ***
// checker: timing relations on the burst sram pins
// assumes sys_clk samples every pin of one bsp_if
`timescale 1ns/1ps
module bsp_assertions #(parameter int ADDR_W = 20) (
   input wire logic              sys_clk,
   input wire logic              nrst,
   input wire logic              k,
   input wire logic              kN,
   input wire logic              load_strobe_n,
   input wire logic              rw,
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic [3:0]        byte_enable_n,
   input wire logic [35:0]       dqHost,
   input wire logic              dqHostOe,
   input wire logic [35:0]       dqDevOe,
   input wire logic              echo_strobe_pos,
   input wire logic              echo_strobe_neg
);
   // ****
   // k rises without a load, saturating
   // ****
   logic       kPrev;
   logic       next_kPrev;
   logic [2:0] idle;
   logic [2:0] next_idle;
   always_comb begin
      next_kPrev = k;
      next_idle  = idle;
      if (k && !kPrev) begin
         next_idle = !load_strobe_n ? 3'h0 : (idle == 3'h7) ? idle : idle + 3'h1;
      end
   end
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         kPrev <= 1'h0;
         idle  <= 3'h0;
      end else begin
         kPrev <= next_kPrev;
         idle  <= next_idle;
      end
   end
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);
   AST_K_PAIR: assert property (k != kN)
      else $error("k pair not complementary");
   AST_CMD_HOLD: assert property ($rose(k) && !load_strobe_n |->
      $stable(addr_in) && $stable(rw))
      else $error("command moved at k rise");
   AST_DATA_HOLD: assert property (($rose(k) || $rose(kN)) && dqHostOe |->
      $stable(dqHost) && $stable(byte_enable_n))
      else $error("write data moved at clock rise");
   AST_READ_DRIVE: assert property ($rose(k) && !load_strobe_n && rw |->
      ##[16:40] (dqDevOe != 36'h0))
      else $error("read burst not driven");
   AST_NO_CONTEND: assert property (dqHostOe |-> dqDevOe == 36'h0)
      else $error("both ends drive data");
   AST_IDLE_RELEASE: assert property (idle >= 3'h4 |-> dqDevOe == 36'h0)
      else $error("data driven while idle");
   AST_ECHO_RUN: assert property ($rose(k) |-> ##[1:12] $rose(echo_strobe_pos))
      else $error("echo strobe stopped");
   AST_OE_ECHO: assert property ($rose(|dqDevOe) |-> ##[0:2] echo_strobe_neg)
      else $error("data without echo edge");
endmodule : bsp_assertions

// *** tb_burst2_sync_sram_port.sv ***
// bench: host and sram joined by bsp_if, read-back scoreboard
// assumes design files and bsp_assertions compiled first
`timescale 1ns/1ps
module tb_burst2_sync_sram_port;
   logic        sys_clk = 1'h0;
   logic        nrst = 1'h0;
   logic        coreSupplyOk = 1'h0;
   logic        singleClock = 1'h0;
   logic        bypassPll = 1'h0;
   logic        reqValid = 1'h0;
   logic        reqWrite = 1'h0;
   logic [19:0] reqAddr = 20'h0;
   logic [35:0] reqData0 = 36'h0;
   logic [35:0] reqData1 = 36'h0;
   logic [3:0]  reqBe0 = 4'h0;
   logic [3:0]  reqBe1 = 4'h0;
   logic        reqAck, rdValid, linkReady, pllLocked;
   logic [35:0] rdData0, rdData1;
   logic [71:0] expQ[$];
   logic [35:0] mem[0:255];
   int          bad_count = 0;
   int          checks = 0;
   bsp_if i_bsp_if ();
   bsp_host #(.SETTLE_CYC(64)) i_bsp_host (.sys_clk(sys_clk), .nrst(nrst), .bus(i_bsp_if),
      .coreSupplyOk(coreSupplyOk), .singleClock(singleClock), .bypassPll(bypassPll),
      .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr), .reqData0(reqData0),
      .reqData1(reqData1), .reqBe0(reqBe0), .reqBe1(reqBe1), .reqAck(reqAck),
      .rdValid(rdValid), .rdData0(rdData0), .rdData1(rdData1), .linkReady(linkReady));
   bsp_device #(.LOCK_EDGES(2)) i_bsp_device (.sys_clk(sys_clk), .nrst(nrst),
      .bus(i_bsp_if), .pllLocked(pllLocked));
   bsp_assertions #(.ADDR_W(20)) i_bsp_assertions (.sys_clk(sys_clk), .nrst(nrst),
      .k(i_bsp_if.k), .kN(i_bsp_if.kN), .load_strobe_n(i_bsp_if.load_strobe_n),
      .rw(i_bsp_if.rw), .addr_in(i_bsp_if.addr_in), .byte_enable_n(i_bsp_if.byte_enable_n),
      .dqHost(i_bsp_if.dqHost), .dqHostOe(i_bsp_if.dqHostOe), .dqDevOe(i_bsp_if.dqDevOe),
      .echo_strobe_pos(i_bsp_if.echo_strobe_pos), .echo_strobe_neg(i_bsp_if.echo_strobe_neg));
   // ****
   // clock, compare and verdict
   // ****
   initial begin
      forever #4 sys_clk = ~sys_clk;
   end
   task automatic cmp(input logic [71:0] got, input logic [71:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : cmp
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : report_and_stop
   task automatic hang;
      bad_count++;
      report_and_stop();
   endtask : hang
   function automatic logic [35:0] rnd;
      return 36'({$urandom(), $urandom()});
   endfunction : rnd
   // one request held until acknowledged, model noted first
   task automatic req(input logic wr, input logic [7:0] a, input logic [35:0] d0, d1,
                      input logic [3:0] b0, b1);
      int n;
      if (wr) begin
         for (int i = 0; i < 4; i++) begin
            if (b0[i]) mem[a][9*i +: 9] = d0[9*i +: 9];
            if (b1[i]) mem[a ^ 8'h1][9*i +: 9] = d1[9*i +: 9];
         end
      end else expQ.push_back({mem[a ^ 8'h1], mem[a]});
      @(posedge sys_clk);
      reqValid <= 1'h1;
      reqWrite <= wr;
      reqAddr <= 20'(a);
      reqData0 <= d0;
      reqData1 <= d1;
      reqBe0 <= b0;
      reqBe1 <= b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (reqAck !== 1'h1 && n < 200);
      if (n >= 200) hang();
      reqValid <= 1'h0;
   endtask : req
   // scoreboard: oldest noted read against each returned burst
   always @(posedge sys_clk) begin
      if (rdValid === 1'h1) begin
         if (expQ.size() == 0) cmp(72'h0, 72'h1);
         else cmp({rdData1, rdData0}, expQ.pop_front());
      end
      if (singleClock && linkReady === 1'h1 && (i_bsp_if.c & i_bsp_if.cN) !== 1'h1) begin
         cmp(72'h0, 72'h1);
      end
   end
   task automatic run(input logic sc, input logic bp);
      int n;
      logic [7:0] a;
      @(posedge sys_clk);
      nrst <= 1'h0;
      coreSupplyOk <= 1'h0;
      singleClock <= sc;
      bypassPll <= bp;
      repeat (5) @(posedge sys_clk);
      nrst <= 1'h1;
      repeat (12) @(posedge sys_clk);
      cmp(72'({linkReady, i_bsp_if.k}), 72'h0);
      cmp(72'(pllLocked), 72'(bp & !sc));
      coreSupplyOk <= 1'h1;
      for (n = 0; n < 3000 && linkReady !== 1'h1; n++) @(posedge sys_clk);
      if (n >= 3000) hang();
      cmp(72'(i_bsp_if.pll_bypass_n), 72'(sc | !bp));
      cmp(72'(pllLocked), 72'h1);
      for (int i = 0; i < 4; i++) begin
         a = 8'($urandom_range(255));
         a[0] = i[0];
         req(1'h1, a, rnd(), rnd(), 4'hF, 4'hF);
         req(1'h1, a, rnd(), rnd(), 4'($urandom()), 4'($urandom()));
         req(1'h0, a, 36'h0, 36'h0, 4'h0, 4'h0);
         req(1'h0, a ^ 8'h1, 36'h0, 36'h0, 4'h0, 4'h0);
      end
      for (n = 0; n < 500 && expQ.size() > 0; n++) @(posedge sys_clk);
      if (expQ.size() > 0) hang();
      repeat (100) @(posedge sys_clk);
      $display("test single=%0d bypass=%0d done", sc, bp);
   endtask : run
   initial begin
      void'($urandom(82));
      run(1'h0, 1'h1);
      run(1'h1, 1'h0);
      report_and_stop();
   end
endmodule : tb_burst2_sync_sram_port
